// ==== inc/card_pin_pkg.sv ====
// Shared constants and types for the card reader pin control block
`default_nettype none
package card_pin_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // Control register field positions
  localparam int IRQ_SEL_BIT = 0;
  localparam int INT_PULLUP_BIT = 1;
  localparam int MON_EN_BIT = 2;
  localparam int TRANSP_BIT = 3;
  localparam int SHUTDOWN_BIT = 4;
  localparam int VOLT_3V_BIT = 5;
  localparam int CTRL_W = 6;
  // Control register reset value
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  // Status register field positions
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_ADDR_VALID_BIT = 3;
  localparam int ST_PRES_BIT = 4;
  localparam int ST_SHUT_BIT = 5;
  localparam int ST_PF_BIT = 6;
  // Interrupt bit positions
  localparam int EV_PRES_BIT = 0;
  localparam int EV_PFAIL_BIT = 1;
  localparam int EV_ADDR_BIT = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  // Strap address width and capture edge of the master clock
  localparam int ADDR_W = 3;
  localparam int STRAP_EDGE = 11;
  localparam int EDGE_CNT_W = 4;
  // Configuration bits as one bundle
  typedef struct packed {
    logic volt_3v;
    logic shutdown;
    logic transparent;
    logic monitor_en;
    logic int_pullup;
    logic irq_select;
  } cfg_s;
  // Captured strap address
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } strap_s;
endpackage
`default_nettype wire

// ==== rtl/strap_latch.sv ====
// Captures the address straps on a chosen master clock edge after reset
`default_nettype none
module strap_latch
  import card_pin_pkg::*;
#(
  parameter int CAPTURE_EDGE = STRAP_EDGE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dev_rst,
  input wire logic master_clk,
  input wire logic [ADDR_W-1:0] straps,
  output strap_s strap
);
  logic mclk_q; // Previous master clock sample
  logic [EDGE_CNT_W-1:0] edge_cnt; // Rising edges seen since release
  logic [EDGE_CNT_W-1:0] next_edge_cnt;
  strap_s next_strap;
  logic mclk_rise;

  assign mclk_rise = master_clk & ~mclk_q;

  // Count master clock rises, latch straps on the chosen one
  always_comb begin
    next_edge_cnt = edge_cnt;
    next_strap = strap;
    if (dev_rst) begin
      // Held in reset: forget the old address
      next_edge_cnt = '0;
      next_strap = '0;
    end else if (mclk_rise && !strap.valid) begin
      next_edge_cnt = edge_cnt + 1'b1;
      if (next_edge_cnt == EDGE_CNT_W'(CAPTURE_EDGE)) begin
        next_strap.addr = straps;
        next_strap.valid = 1'b1;
      end
    end
  end

  // Register the counter and captured address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_q <= 1'b0;
      edge_cnt <= '0;
      strap <= '0;
    end else begin
      mclk_q <= master_clk;
      edge_cnt <= next_edge_cnt;
      strap <= next_strap;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/card_pin_ctrl.sv ====
// Host side pin control of a smart card reader interface, APB slave
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none
module card_pin_ctrl
  import card_pin_pkg::*;
#(
  parameter int CAPTURE_EDGE = STRAP_EDGE
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Master clock input, sampled as a level
  input wire logic master_clk,
  // Address straps, reused as card clock/reset pass-through pins and the supply voltage select
  input wire logic addr_strap_hi_clk_pass,
  input wire logic addr_strap_mid_rst_pass,
  input wire logic addr_strap_lo_volt_sel,
  // Card side outputs
  input wire logic seq_card_clock,
  input wire logic seq_card_reset,
  output logic card_clock_out,
  output logic card_reset_out,
  // Supply choice: high picks 3V, low picks 5V
  input wire logic hw_activation,
  output logic card_supply_3v_sel,
  // Card presence and presence/interrupt open-drain pin
  input wire logic card_present,
  output logic presence_or_irq_out,
  output logic presence_or_irq_oe,
  output logic presence_pullup_en,
  // Open-drain reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Power monitors
  input wire logic power_on_reset,
  input wire logic core_supply_fail,
  input wire logic io_supply_fail,
  // Level interrupt
  output logic irq
);
  cfg_s cfg; // Software configuration
  cfg_s next_cfg;
  strap_s strap; // Captured address
  logic strap_valid_q; // Address valid flag one cycle ago
  logic [EV_W-1:0] irq_stat; // Sticky events
  logic [EV_W-1:0] next_irq_stat;
  logic [EV_W-1:0] irq_mask; // Event enables
  logic [EV_W-1:0] next_irq_mask;
  logic [EV_W-1:0] events; // One-cycle event pulses, power fail as a level while it lasts
  logic rst_pin_q; // Sampled reset pin level
  logic dev_rst; // Internal reset while pin low
  logic pres_q; // Previous card presence
  logic pf_hold; // Power fail drive held
  logic next_pf_hold;
  logic pf_now; // Monitored supply failing
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic setup_ph; // APB setup cycle
  logic wr_en; // APB write taken
  logic clk_out_d;
  logic rst_out_d;
  logic volt_d;
  logic pin_assert_d;
  logic pin_irq_d;
  logic pin_drive_low;

  // Address decode helper
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == CTRL_OFS) || (a == STATUS_OFS) ||
                 (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction

  // Strap capture after reset release
  strap_latch #(
    .CAPTURE_EDGE(CAPTURE_EDGE)
  ) u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .dev_rst(dev_rst),
    .master_clk(master_clk),
    .straps({addr_strap_hi_clk_pass, addr_strap_mid_rst_pass,
             addr_strap_lo_volt_sel}),
    .strap(strap)
  );

  // Low reset pin holds configuration, interrupts and strap capture in reset
  assign dev_rst = ~rst_pin_q;

  // APB phases; zero wait states
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;

  // Monitored supply failure
  assign pf_now = cfg.monitor_en & (core_supply_fail | io_supply_fail);

  // Event pulses and power fail level
  always_comb begin
    events = '0;
    events[EV_PRES_BIT] = card_present ^ pres_q;
    events[EV_PFAIL_BIT] = pf_now;
    events[EV_ADDR_BIT] = 1'b0;
    // Capture seen as the valid flag rising, one cycle after the latch
    if (!dev_rst && strap.valid && !strap_valid_q) begin
      events[EV_ADDR_BIT] = 1'b1;
    end
  end

  // Configuration register next value
  always_comb begin
    next_cfg = cfg;
    if (dev_rst) begin
      // Defaults while held in reset, also leaves shutdown
      next_cfg = cfg_s'(CTRL_RST);
    end else if (wr_en && paddr == CTRL_OFS) begin
      next_cfg = cfg_s'(pwdata[CTRL_W-1:0]);
    end
  end

  // Interrupt status and mask next values
  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (dev_rst) begin
      next_irq_stat = EV_RST;
      next_irq_mask = EV_RST;
    end else begin
      if (wr_en && paddr == IRQ_STAT_OFS) begin
        // Write one to clear
        next_irq_stat = irq_stat & ~pwdata[EV_W-1:0];
      end
      if (wr_en && paddr == IRQ_MASK_OFS) begin
        next_irq_mask = pwdata[EV_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | events;
    end
  end

  // Power fail drive holds until the failure is gone
  always_comb begin
    next_pf_hold = pf_hold;
    if (pf_now) begin
      next_pf_hold = 1'b1;
    end else if (!core_supply_fail && !io_supply_fail) begin
      next_pf_hold = 1'b0;
    end
  end

  // Read data, prepared in the setup cycle
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (setup_ph) begin
      next_prdata = '0;
      next_pslverr = ~known_addr(paddr);
      unique case (paddr)
        CTRL_OFS: begin
          next_prdata[CTRL_W-1:0] = cfg;
        end
        STATUS_OFS: begin
          next_prdata[ST_ADDR_LSB +: ADDR_W] = strap.addr;
          next_prdata[ST_ADDR_VALID_BIT] = strap.valid;
          next_prdata[ST_PRES_BIT] = card_present;
          next_prdata[ST_SHUT_BIT] = cfg.shutdown;
          next_prdata[ST_PF_BIT] = pf_hold;
        end
        IRQ_STAT_OFS: begin
          next_prdata[EV_W-1:0] = irq_stat;
        end
        IRQ_MASK_OFS: begin
          next_prdata[EV_W-1:0] = irq_mask;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end else if (psel) begin
      next_pslverr = pslverr;
    end
  end

  // Pin output next values
  always_comb begin
    // Card clock and reset: straps pass through in transparent mode
    if (cfg.transparent) begin
      clk_out_d = addr_strap_hi_clk_pass;
      rst_out_d = addr_strap_mid_rst_pass;
    end else begin
      clk_out_d = seq_card_clock;
      rst_out_d = seq_card_reset;
    end
    // Supply voltage choice
    if (hw_activation) begin
      volt_d = addr_strap_lo_volt_sel;
    end else begin
      volt_d = cfg.volt_3v;
    end
    // Presence or interrupt source for the open-drain pin
    pin_irq_d = |(irq_stat & irq_mask);
    if (cfg.irq_select) begin
      pin_assert_d = pin_irq_d;
    end else begin
      pin_assert_d = card_present;
    end
    // Reset pin pulled low on POR or held power fail
    pin_drive_low = power_on_reset | pf_hold;
  end

  // Open-drain pins only ever drive low
  assign presence_or_irq_out = 1'b0;
  assign reset_pin_out = 1'b0;

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= cfg_s'(CTRL_RST);
      irq_stat <= EV_RST;
      irq_mask <= EV_RST;
      rst_pin_q <= 1'b0;
      strap_valid_q <= 1'b0;
      pres_q <= 1'b0;
      pf_hold <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      card_clock_out <= 1'b0;
      card_reset_out <= 1'b0;
      card_supply_3v_sel <= 1'b0;
      presence_or_irq_oe <= 1'b0;
      presence_pullup_en <= 1'b0;
      reset_pin_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rst_pin_q <= reset_pin_in;
      strap_valid_q <= strap.valid;
      pres_q <= card_present;
      pf_hold <= next_pf_hold;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      card_clock_out <= clk_out_d;
      card_reset_out <= rst_out_d;
      card_supply_3v_sel <= volt_d;
      presence_or_irq_oe <= pin_assert_d;
      presence_pullup_en <= cfg.int_pullup;
      reset_pin_oe <= pin_drive_low;
      irq <= pin_irq_d;
    end
  end
endmodule
`default_nettype wire

// ==== verif/card_pin_ctrl_monitor.sv ====
// Port checker of the card reader pin control block
`default_nettype none
module card_pin_ctrl_monitor
  import card_pin_pkg::*;
#(
  parameter int CAPTURE_EDGE = STRAP_EDGE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic presence_or_irq_out,
  input wire logic presence_or_irq_oe,
  input wire logic presence_pullup_en,
  input wire logic card_present,
  input wire logic irq,
  input wire logic hw_activation,
  input wire logic addr_strap_lo_volt_sel,
  input wire logic card_supply_3v_sel,
  input wire logic power_on_reset,
  input wire logic core_supply_fail,
  input wire logic io_supply_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks run on the bus clock and rest during bus reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pull-up follows the written control bit
  a_pullup_write: assert property (
    psel && penable && pwrite && paddr == CTRL_OFS && reset_pin_in
    && $past(reset_pin_in) |-> ##2
    presence_pullup_en == $past(pwdata[INT_PULLUP_BIT], 2))
    else $error("pull-up does not follow control write");
  // Power-on reset pulls the reset pin
  a_por_drive: assert property (
    power_on_reset [*2] |=> reset_pin_oe)
    else $error("reset pin not driven during power-on reset");
  // Pin let go once every cause is gone
  a_pin_release: assert property (
    (!power_on_reset && !core_supply_fail && !io_supply_fail) [*3]
    |=> !reset_pin_oe)
    else $error("reset pin still driven without cause");
  // Held reset pin clears interrupts
  a_rst_irq: assert property (
    (!reset_pin_in) [*4] |-> !irq)
    else $error("interrupt survives pin reset");
  // Held reset pin clears configuration
  a_rst_cfg: assert property (
    (!reset_pin_in) [*4] |-> !presence_pullup_en)
    else $error("configuration survives pin reset");
  // Nothing to report keeps the presence line released
  a_pres_idle: assert property (
    (!card_present && !irq) [*2] |-> !presence_or_irq_oe)
    else $error("presence line pulled with no cause");
  // Open-drain pins only ever pull low
  a_od_low: assert property (
    !reset_pin_out && !presence_or_irq_out)
    else $error("open-drain pin driven high");
  // Hardware activation takes supply choice from the low strap
  a_volt_strap: assert property (
    hw_activation |=> card_supply_3v_sel == $past(addr_strap_lo_volt_sel))
    else $error("supply choice does not follow strap");
  // Main scenarios reached
  c_irq: cover property (irq);
  c_pin_drive: cover property (reset_pin_oe && !power_on_reset);
  c_pullup: cover property (presence_pullup_en);
endmodule
bind card_pin_ctrl card_pin_ctrl_monitor #(.CAPTURE_EDGE(CAPTURE_EDGE))
  i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .reset_pin_in(reset_pin_in), .reset_pin_oe(reset_pin_oe),
    .reset_pin_out(reset_pin_out),
    .presence_or_irq_out(presence_or_irq_out),
    .presence_or_irq_oe(presence_or_irq_oe),
    .presence_pullup_en(presence_pullup_en), .card_present(card_present),
    .irq(irq), .hw_activation(hw_activation),
    .addr_strap_lo_volt_sel(addr_strap_lo_volt_sel),
    .card_supply_3v_sel(card_supply_3v_sel),
    .power_on_reset(power_on_reset), .core_supply_fail(core_supply_fail),
    .io_supply_fail(io_supply_fail)
  );
`default_nettype wire

// ==== verif/host_model.sv ====
// Board and host side of the shared reset and presence lines
`default_nettype none
module host_model (
  input wire logic reset_pin_oe,
  input wire logic host_rst,
  input wire logic presence_or_irq_oe,
  output logic reset_pin_in,
  output logic pres_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-and with the board pull-up: low while any party pulls
  assign reset_pin_in = !(reset_pin_oe || host_rst);
  // Board pull-up on presence; host reads it only after setup
  assign pres_wire = !presence_or_irq_oe;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench of the card reader pin control block
`default_nettype none
module testbench
  import card_pin_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // Bus side
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  // Pin side stimulus
  logic master_clk = 0, hw_activation = 0, card_present = 0;
  logic addr_strap_hi_clk_pass = 1, addr_strap_mid_rst_pass = 0;
  logic addr_strap_lo_volt_sel = 1, seq_card_clock = 0, seq_card_reset = 0;
  logic power_on_reset = 1, core_supply_fail = 0, io_supply_fail = 0;
  logic host_rst = 0;
  // Pin side results
  logic card_clock_out, card_reset_out, card_supply_3v_sel, irq;
  logic presence_or_irq_out, presence_or_irq_oe, presence_pullup_en;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, pres_wire;
  int error_cnt = 0, num_checks = 0;
  // Rows: control, {present,hw,hi,mid,lo,seqclk,seqrst}, expected pins
  logic [19:0] rows [4] = '{{8'h00, 7'b1000010, 5'b10100},
    {8'h22, 7'b0000101, 5'b01011}, {8'h09, 7'b1110100, 5'b00101},
    {8'h08, 7'b0101011, 5'b00010}};
  // Device under test, every pin named
  card_pin_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clk(master_clk),
    .addr_strap_hi_clk_pass(addr_strap_hi_clk_pass),
    .addr_strap_mid_rst_pass(addr_strap_mid_rst_pass),
    .addr_strap_lo_volt_sel(addr_strap_lo_volt_sel),
    .seq_card_clock(seq_card_clock), .seq_card_reset(seq_card_reset),
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .hw_activation(hw_activation), .card_supply_3v_sel(card_supply_3v_sel),
    .card_present(card_present), .presence_or_irq_out(presence_or_irq_out),
    .presence_or_irq_oe(presence_or_irq_oe),
    .presence_pullup_en(presence_pullup_en), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .power_on_reset(power_on_reset), .core_supply_fail(core_supply_fail),
    .io_supply_fail(io_supply_fail), .irq(irq)
  );
  // Board wiring and host pull of the shared lines
  host_model i_host (
    .reset_pin_oe(reset_pin_oe), .host_rst(host_rst),
    .presence_or_irq_oe(presence_or_irq_oe), .reset_pin_in(reset_pin_in),
    .pres_wire(pres_wire)
  );
  always #5 pclk = ~pclk;
  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 100);
    if (n >= 100) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Rising edges of the master clock, slower than the bus clock
  task automatic mc(input int n);
    repeat (2 * n) begin
      repeat (2) @(posedge pclk);
      master_clk <= ~master_clk;
    end
  endtask
  // Hang guard
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("por_drive", reset_pin_oe, 1'h1);
    power_on_reset <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("pin_release", reset_pin_oe, 1'h0);
    // Strap address taken on exactly the counted edge
    mc(STRAP_EDGE - 1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("addr_early", rd[ST_ADDR_VALID_BIT], 1'h0);
    mc(1);
    repeat (2) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("addr", rd[3:0], 4'hd);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("addr_event", rd[EV_ADDR_BIT], 1'h1);
    // Pin routing table
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_OFS, {24'h0, rows[i][19:12]});
      {card_present, hw_activation, addr_strap_hi_clk_pass,
        addr_strap_mid_rst_pass, addr_strap_lo_volt_sel, seq_card_clock,
        seq_card_reset} <= rows[i][11:5];
      repeat (3) @(posedge pclk);
      chk("pins", {presence_or_irq_oe, presence_pullup_en, card_clock_out,
        card_reset_out, card_supply_3v_sel}, rows[i][4:0]);
    end
    // Interrupt on the presence line: raise, mask, clear
    apb(1'b1, IRQ_STAT_OFS, 32'h7);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h1);
    card_present <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("irq_set", irq, 1'h1);
    chk("pin_irq", presence_or_irq_oe, 1'h1);
    chk("pres_line", pres_wire, 1'h0);
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", irq, 1'h0);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    apb(1'b1, IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clear", irq, 1'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", err, 1'h1);
    chk("unmapped_data", rd, 32'h0);
    // Host pulls reset while in shutdown; write meanwhile is lost
    apb(1'b1, CTRL_OFS, 32'h12);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("shut_on", rd[ST_SHUT_BIT], 1'h1);
    host_rst <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("rst_pullup", presence_pullup_en, 1'h0);
    apb(1'b1, CTRL_OFS, 32'h2);
    host_rst <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("write_lost", presence_pullup_en, 1'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("shut_off", rd[ST_SHUT_BIT], 1'h0);
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk("mask_default", rd, 32'h0);
    // Monitored supply failure resets through the pin
    apb(1'b1, CTRL_OFS, 32'h4);
    core_supply_fail <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pf_drive", reset_pin_oe, 1'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("pf_cfg", rd, 32'h0);
    core_supply_fail <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("pf_release", reset_pin_oe, 1'h0);
    // Host rewrites setup; unmonitored failure is not passed on
    apb(1'b1, CTRL_OFS, 32'h0);
    io_supply_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pf_unmonitored", reset_pin_oe, 1'h0);
    io_supply_fail <= 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
